// ---- include/dpfs_pkg.sv ----
// Purpose: Shared constants and types of the disk power and fault sequencer.
// Assumes: 20 MHz core clock.
// Notes: Register offsets are byte addresses on a 32-bit APB.
package dpfs_pkg;
    // =========================================================
    // Timing
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned CLK_NS = 50;
    localparam int unsigned SPIN_S = 15;
    localparam int unsigned STOP_S = 15;
    localparam int unsigned WF_NS = 4000;
    localparam int unsigned SPIN_CYC_DEF = SPIN_S * CLK_HZ;
    localparam int unsigned STOP_CYC_DEF = STOP_S * CLK_HZ;
    localparam int unsigned WF_CYC = WF_NS / CLK_NS;
    // =========================================================
    // Registers
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CFG = 12'h004;
    localparam logic [11:0] OFS_STAT = 12'h008;
    localparam logic [11:0] OFS_CODE = 12'h00c;
    localparam int CTRL_START = 0;
    localparam int CTRL_REMOTE = 1;
    localparam int CTRL_CLR = 2;
    localparam int CFG_SPAN_LSB = 0;
    localparam int CFG_ADDR_LSB = 8;
    localparam int STAT_FLT_LSB = 0;
    localparam int STAT_ST_LSB = 8;
    localparam int STAT_READY = 16;
    localparam int STAT_START = 17;
    localparam int STAT_LAMP = 18;
    localparam logic [6:0] SPAN_RST = 7'h01;
    localparam logic [3:0] ADDR_RST = 4'h0;
    // =========================================================
    // Fault latch positions and tag command
    localparam int NFLT = 6;
    localparam int F_WR = 0;
    localparam int F_HS = 1;
    localparam int F_OC = 2;
    localparam int F_RW = 3;
    localparam int F_SK = 4;
    localparam int F_V = 5;
    localparam logic [3:0] TAG_CLR = 4'h3;
    // =========================================================
    // Sequencer states
    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_SPIN = 6'h02,
        ST_HOME = 6'h04,
        ST_RDY = 6'h08,
        ST_RETR = 6'h10,
        ST_BRK = 6'h20
    } dpfs_state_t;
endpackage

// ---- include/dpfs_flt_if.sv ----
// Purpose: Carries fault causes and clears to the fault latch bank.
// Assumes: Both ends on core_clk.
// Notes: Latched flags and seek code come back to the sequencer.
`timescale 1ns/1ps
interface dpfs_flt_if;
    logic [5:0] cond;
    logic clr_all;
    logic clr_seek;
    logic [7:0] code_in;
    logic [5:0] lat;
    logic [7:0] code;
    modport ctl (output cond, output clr_all, output clr_seek,
                 output code_in, input lat, input code);
    modport bank (input cond, input clr_all, input clr_seek,
                  input code_in, output lat, output code);
endinterface

// ---- rtl/dpfs_fault_latch.sv ----
// Purpose: Sticky fault latches with seek error code.
// Assumes: Causes are synchronous to core_clk.
// Notes: A cause present during a clear keeps its latch set.
`timescale 1ns/1ps
module dpfs_fault_latch
    import dpfs_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rstn,
    // Latch bank side.
    dpfs_flt_if.bank f
);
    // =========================================================
    // Latches
    // Set wins over clear so an event in the clear cycle is kept.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            f.lat <= '0;
        end else begin
            for (int i = 0; i < NFLT; i++) begin
                if (f.cond[i]) begin
                    f.lat[i] <= 1'b1;
                end else if (f.clr_all || (i == F_SK && f.clr_seek)) begin
                    f.lat[i] <= 1'b0;
                end
            end
        end
    end

    // The code follows the latest seek failure and clears with its latch.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            f.code <= 8'h00;
        end else if (f.cond[F_SK]) begin
            f.code <= f.code_in;
        end else if (f.clr_all || f.clr_seek) begin
            f.code <= 8'h00;
        end
    end
endmodule

// ---- rtl/dpfs_sequencer.sv ----
// Purpose: Power on/off sequencer and fault logic of a fixed disk drive.
// Assumes: Pins are asynchronous; APB on core_clk with no wait states.
// Notes: Long timeouts are parameters so a bench can shorten them.
`timescale 1ns/1ps
module dpfs_sequencer
    import dpfs_pkg::*;
#(
    parameter int unsigned SPIN_CYC = SPIN_CYC_DEF,
    parameter int unsigned STOP_CYC = STOP_CYC_DEF,
    parameter int NH = 8
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rstn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Controller power lines and command.
    input wire logic pwr_pick,
    input wire logic pwr_hold,
    input wire logic [3:0] tag_code,
    input wire logic bus_bit4,
    input wire logic [3:0] sel_addr,
    // Drive sensors.
    input wire logic dc_ok,
    input wire logic at_speed,
    input wire logic retract_cond,
    input wire logic heads_home,
    input wire logic seek_done,
    input wire logic seek_fail,
    input wire logic [7:0] seek_code,
    input wire logic on_cyl,
    input wire logic index_mark,
    input wire logic slot_tick,
    // Read/write monitors.
    input wire logic write_gate,
    input wire logic read_gate,
    input wire logic write_current,
    input wire logic write_active,
    input wire logic [NH-1:0] head_sel,
    // Drive controls and status.
    output logic brake_energize,
    output logic motor_enable,
    output logic home_cylinder_seek,
    output logic retract_req,
    output logic drive_ready,
    output logic unit_selected,
    output logic sector_pulse,
    output logic clear_fault_lamp,
    output logic [5:0] fault_flags
);
    localparam int SW = 33 + NH;
    // Reset to the idle pin levels (dc good, on cylinder, current on), so
    // the empty synchroniser cannot latch a false fault after reset.
    localparam logic [SW-1:0] SYNC_RST = {{(SW - 14){1'b0}}, 14'h2084};

    dpfs_flt_if flt ();
    dpfs_state_t st_reg;
    logic [SW-1:0] s1_reg, s2_reg;
    logic [31:0] cnt_reg;
    logic [7:0] wf_cnt_reg;
    logic [6:0] slot_reg, span_reg;
    logic [3:0] addr_reg;
    logic start_reg, remote_reg, lclr_reg, idx_q_reg, slot_q_reg;
    logic pick, hold, dcok, spd, rcond, hhome, sdone, sfail, ocyl, idx;
    logic slot, wg, rg, wcur, wact, bit4;
    logic [3:0] tag, uaddr;
    logic [7:0] scode;
    logic [NH-1:0] heads;
    logic go_ok, line_ok, rflt, off_req, wr_en, rd_en, spin_done, stop_done;

    // Two or more bits set.
    function automatic logic multi_hot(input logic [NH-1:0] v);
        return (v & (v - 1'b1)) != '0;
    endfunction

    // =========================================================
    // Pin synchroniser
    // Only the second stage is unpacked and read by logic.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= SYNC_RST;
            s2_reg <= SYNC_RST;
        end else begin
            s1_reg <= {tag_code, bus_bit4, sel_addr, seek_code, head_sel,
                       pwr_pick, pwr_hold, dc_ok, at_speed, retract_cond,
                       heads_home, seek_done, seek_fail, on_cyl, index_mark,
                       slot_tick, write_gate, read_gate, write_current,
                       write_active, 1'b0};
            s2_reg <= s1_reg;
        end
    end
    logic unused_pad;
    assign {tag, bit4, uaddr, scode, heads, pick, hold, dcok, spd, rcond,
            hhome, sdone, sfail, ocyl, idx, slot, wg, rg, wcur, wact,
            unused_pad} = s2_reg;

    // =========================================================
    // Sequencer conditions
    assign line_ok = pick && hold;
    assign go_ok = start_reg && dcok && !rcond &&
                   (!remote_reg || line_ok);
    assign rflt = !dcok || rcond ||
                  (!spd && (st_reg == ST_HOME || st_reg == ST_RDY));
    assign off_req = !start_reg || (remote_reg && !line_ok) || rflt;
    assign spin_done = cnt_reg >= SPIN_CYC - 1;
    assign stop_done = cnt_reg >= STOP_CYC - 1;

    // =========================================================
    // Power sequencer
    // The power-off time runs from retract entry through the brake
    // phase, so a jammed retract still ends in braking in time.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= ST_OFF;
            cnt_reg <= 32'h0000_0000;
        end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
            case (st_reg)
                ST_OFF: begin
                    cnt_reg <= 32'h0000_0000;
                    if (go_ok) begin
                        st_reg <= ST_SPIN;
                    end
                end
                ST_SPIN: begin
                    if (off_req) begin
                        st_reg <= ST_RETR;
                        cnt_reg <= 32'h0000_0000;
                    end else if (spin_done && spd) begin
                        st_reg <= ST_HOME;
                    end
                end
                ST_HOME: begin
                    if (off_req) begin
                        st_reg <= ST_RETR;
                        cnt_reg <= 32'h0000_0000;
                    end else if (sdone) begin
                        st_reg <= ST_RDY;
                    end
                end
                ST_RDY: begin
                    if (off_req) begin
                        st_reg <= ST_RETR;
                        cnt_reg <= 32'h0000_0000;
                    end
                end
                ST_RETR: begin
                    if (hhome || stop_done) begin
                        st_reg <= ST_BRK;
                    end
                    // A jammed retract keeps its count, so braking ends
                    // within the stop time.
                    if (stop_done) begin
                        cnt_reg <= cnt_reg;
                    end
                end
                ST_BRK: begin
                    if (stop_done) begin
                        st_reg <= ST_OFF;
                    end
                end
                default: begin
                    st_reg <= ST_OFF;
                end
            endcase
        end
    end

    // Brake coil and motor always switch in the same cycle.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            brake_energize <= 1'b0;
            motor_enable <= 1'b0;
            home_cylinder_seek <= 1'b0;
            retract_req <= 1'b0;
            drive_ready <= 1'b0;
        end else begin
            brake_energize <= st_reg inside {ST_SPIN, ST_HOME, ST_RDY,
                                             ST_RETR};
            motor_enable <= st_reg inside {ST_SPIN, ST_HOME, ST_RDY,
                                           ST_RETR};
            home_cylinder_seek <= st_reg == ST_SPIN && !off_req &&
                                  spin_done && spd;
            retract_req <= st_reg == ST_RETR;
            drive_ready <= st_reg == ST_RDY;
        end
    end

    // =========================================================
    // Fault causes
    assign wr_en = wg && (wcur ? 1'b0 : wact); // Writing without current.
    assign rd_en = wf_cnt_reg == WF_CYC[7:0];
    assign flt.cond[F_WR] = wr_en || (rd_en && !wact);
    assign flt.cond[F_HS] = multi_hot(heads);
    assign flt.cond[F_OC] = (wg || rg) && !ocyl;
    assign flt.cond[F_RW] = wg && rg;
    assign flt.cond[F_SK] = sfail;
    assign flt.cond[F_V] = !dcok;
    assign flt.clr_all = lclr_reg || (tag == TAG_CLR && bit4);
    assign flt.clr_seek = home_cylinder_seek;
    assign flt.code_in = scode;

    // Cycles since write gate rose without writing; saturates.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wf_cnt_reg <= 8'h00;
        end else if (!wg || wact) begin
            wf_cnt_reg <= 8'h00;
        end else if (!rd_en) begin
            wf_cnt_reg <= wf_cnt_reg + 8'h01;
        end
    end

    dpfs_fault_latch u_lat (
        .core_clk(core_clk),
        .rstn(rstn),
        .f(flt.bank)
    );

    // Lamp lights on any latched fault and goes out only on local clear.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            clear_fault_lamp <= 1'b0;
            fault_flags <= 6'h00;
        end else begin
            fault_flags <= flt.lat;
            if (flt.lat != '0) begin
                clear_fault_lamp <= 1'b1;
            end else if (lclr_reg) begin
                clear_fault_lamp <= 1'b0;
            end
        end
    end

    // =========================================================
    // Sector pulses and unit address
    // A pulse every span slots from index; span sets sectors per turn.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            idx_q_reg <= 1'b0;
            slot_q_reg <= 1'b0;
            slot_reg <= 7'h00;
            sector_pulse <= 1'b0;
            unit_selected <= 1'b0;
        end else begin
            idx_q_reg <= idx;
            slot_q_reg <= slot;
            sector_pulse <= 1'b0;
            unit_selected <= uaddr == addr_reg;
            if (idx && !idx_q_reg) begin
                slot_reg <= 7'h00;
                sector_pulse <= 1'b1;
            end else if (slot && !slot_q_reg) begin
                if (slot_reg + 7'h01 >= span_reg) begin
                    slot_reg <= 7'h00;
                    sector_pulse <= 1'b1;
                end else begin
                    slot_reg <= slot_reg + 7'h01;
                end
            end
        end
    end

    // =========================================================
    // APB slave
    // Read data comes from a flop loaded in the setup phase, with no wait state.
    logic acc, wr_acc;
    assign acc = psel && penable && pready;
    assign wr_acc = acc && pwrite;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            start_reg <= 1'b0;
            remote_reg <= 1'b0;
            lclr_reg <= 1'b0;
            span_reg <= SPAN_RST;
            addr_reg <= ADDR_RST;
        end else begin
            lclr_reg <= 1'b0;
            if (st_reg == ST_BRK && stop_done && !remote_reg) begin
                start_reg <= 1'b0;
            end
            if (wr_acc && paddr == OFS_CTRL) begin
                if (pwdata[CTRL_START]) begin
                    start_reg <= !start_reg;
                end
                remote_reg <= pwdata[CTRL_REMOTE];
                lclr_reg <= pwdata[CTRL_CLR];
            end
            if (wr_acc && paddr == OFS_CFG) begin
                span_reg <= pwdata[CFG_SPAN_LSB +: 7];
                addr_reg <= pwdata[CFG_ADDR_LSB +: 4];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable &&
                       !(paddr inside {OFS_CTRL, OFS_CFG, OFS_STAT,
                                       OFS_CODE});
            prdata <= 32'h0000_0000;
            case (paddr)
                OFS_CTRL: prdata <= {30'h0, remote_reg, start_reg};
                OFS_CFG: prdata <= {20'h0, addr_reg, 1'b0, span_reg};
                OFS_STAT: prdata <= {13'h0, clear_fault_lamp, start_reg,
                                     drive_ready, 2'h0, st_reg,
                                     2'h0, flt.lat};
                OFS_CODE: prdata <= {24'h0, flt.code};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // =========================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_wg_late;
        wg && !wact && !rd_en ##1 rd_en && !wact;
    endsequence
    property p_wr_late;
        s_wg_late |=> flt.lat[F_WR];
    endproperty
    a_wr_late: assert property (p_wr_late) else $error("late write");
    property p_hs;
        multi_hot(heads) |=> flt.lat[F_HS];
    endproperty
    a_hs: assert property (p_hs) else $error("head select");
    property p_oc;
        (wg || rg) && !ocyl |=> flt.lat[F_OC] ##1 fault_flags[F_OC];
    endproperty
    a_oc: assert property (p_oc) else $error("off cylinder");
    property p_rw;
        wg && rg |=> flt.lat[F_RW];
    endproperty
    a_rw: assert property (p_rw) else $error("read and write");
    property p_hold;
        flt.lat[F_V] && !flt.clr_all |=> flt.lat[F_V];
    endproperty
    a_hold: assert property (p_hold) else $error("latch lost");
    property p_clr;
        lclr_reg && flt.cond == '0 |=> flt.lat == '0;
    endproperty
    a_clr: assert property (p_clr) else $error("clear failed");
    property p_pair;
        brake_energize == motor_enable;
    endproperty
    a_pair: assert property (p_pair) else $error("brake split");
    sequence s_seek_ok;
        st_reg == ST_HOME && sdone && !off_req;
    endsequence
    property p_rdy;
        $rose(drive_ready) |-> $past(st_reg, 2) == ST_HOME &&
                               $past(sdone, 2);
    endproperty
    a_rdy: assert property (p_rdy) else $error("early ready");
    property p_rdy_next;
        s_seek_ok |=> ##1 drive_ready;
    endproperty
    a_rdy_next: assert property (p_rdy_next) else $error("late ready");
    property p_stop;
        st_reg == ST_BRK |-> cnt_reg < STOP_CYC;
    endproperty
    a_stop: assert property (p_stop) else $error("stop late");
endmodule

// ---- dv/dpfs_ctl_model.sv ----
// Purpose: Behavioural disk controller for the power sequencer bench.
// Assumes: Called from the bench just after core_clk rising edges.
// Notes: Tag lines go back to zero between commands.
`timescale 1ns/1ps
module dpfs_ctl_model (
    // Clock.
    input wire logic core_clk,
    // Power lines and command bus.
    output logic pwr_pick,
    output logic pwr_hold,
    output logic [3:0] tag_code,
    output logic bus_bit4,
    output logic [3:0] sel_addr
);
    // ==========
    // Idle: no sequence ground, no tag, another unit selected.
    initial begin
        pwr_pick = 1'b0;
        pwr_hold = 1'b0;
        tag_code = 4'h0;
        bus_bit4 = 1'b0;
        sel_addr = 4'hf;
    end
    // Pick and hold move together; dropping both ends power.
    task automatic lines(input logic on);
        @(posedge core_clk);
        pwr_pick <= on;
        pwr_hold <= on;
    endtask
    // Held four cycles so it outlasts the pin synchronisers.
    task automatic fault_clear();
        @(posedge core_clk);
        tag_code <= 4'h3;
        bus_bit4 <= 1'b1;
        repeat (4) @(posedge core_clk);
        tag_code <= 4'h0;
        bus_bit4 <= 1'b0;
    endtask
    // Unit selection on the address lines.
    task automatic select(input logic [3:0] a);
        @(posedge core_clk);
        sel_addr <= a;
    endtask
endmodule

// ---- dv/tb_disk_power_fault_sequencer.sv ----
// Purpose: Self-checking bench of the disk power and fault sequencer.
// Assumes: Spin and stop counts shortened to 50 cycles.
// Notes: Pin effects are judged a few cycles late for synchronisers.
`timescale 1ns/1ps
module tb_disk_power_fault_sequencer
    import dpfs_pkg::*;
;
    logic core_clk = 1'b0, rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, se;
    logic pwr_pick, pwr_hold, bus_bit4;
    logic [3:0] tag_code, sel_addr;
    logic dc_ok = 1'b1, at_speed = 1'b0, retract_cond = 1'b0;
    logic heads_home = 1'b0, seek_done = 1'b0, seek_fail = 1'b0;
    logic on_cyl = 1'b1, index_mark = 1'b0, slot_tick = 1'b0;
    logic write_gate = 1'b0, read_gate = 1'b0, write_current = 1'b1;
    logic write_active = 1'b0;
    logic [7:0] seek_code = 8'h0, head_sel = 8'h01;
    logic brake_energize, motor_enable, home_cylinder_seek, retract_req;
    logic drive_ready, unit_selected, sector_pulse, clear_fault_lamp;
    logic [5:0] fault_flags;
    int err_count, samples_checked, cyc, t0, sec_count;

    // Sector pulses are counted here, so a one-cycle pulse is never missed.
    always @(posedge core_clk) begin
        if (sector_pulse === 1'b1) begin
            sec_count++;
        end
    end

    dpfs_sequencer #(.SPIN_CYC(50), .STOP_CYC(50), .NH(8)) dut (
        .core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pwr_pick, .pwr_hold, .tag_code,
        .bus_bit4, .sel_addr, .dc_ok, .at_speed, .retract_cond,
        .heads_home, .seek_done, .seek_fail, .seek_code, .on_cyl,
        .index_mark, .slot_tick, .write_gate, .read_gate,
        .write_current, .write_active, .head_sel, .brake_energize,
        .motor_enable, .home_cylinder_seek, .retract_req, .drive_ready,
        .unit_selected, .sector_pulse, .clear_fault_lamp, .fault_flags);
    dpfs_ctl_model ctl (.core_clk, .pwr_pick, .pwr_hold, .tag_code,
        .bus_bit4, .sel_addr);

    // ==========
    // Clock, and a cycle ceiling so a hang still reaches the verdict.
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // ==========
    // Common tasks.
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // The request is held until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ==========
    // Scenarios.
    task automatic t_reset();
        chk_bit(brake_energize, 1'b0);
        apb(1'b0, OFS_STAT, 32'h0);
        chk_word(rd, 32'h0000_0100);
        apb(1'b1, 12'h010, 32'h5);
        chk_bit(se, 1'b1);
        apb(1'b1, OFS_CFG, 32'h0000_0501);
        apb(1'b0, OFS_CFG, 32'h0);
        chk_word(rd, 32'h0000_0501);
        ctl.select(4'h5);
        waitc(6);
        chk_bit(unit_selected, 1'b1);
        ctl.select(4'h4);
        waitc(6);
        chk_bit(unit_selected, 1'b0);
        $display("test reset_and_unit done");
    endtask
    task automatic t_power_up();
        apb(1'b1, OFS_CTRL, 32'h1);
        t0 = cyc;
        waitc(4);
        chk_bit(brake_energize, 1'b1);
        chk_bit(motor_enable, 1'b1);
        head_sel <= 8'h03;
        seek_fail <= 1'b1;
        seek_code <= 8'h5a;
        waitc(3);
        head_sel <= 8'h01;
        seek_fail <= 1'b0;
        waitc(6);
        chk_word({26'h0, fault_flags}, 32'h12);
        apb(1'b0, OFS_CODE, 32'h0);
        chk_word(rd, 32'h5a);
        at_speed <= 1'b1;
        while (home_cylinder_seek !== 1'b1) @(posedge core_clk);
        chk_bit((cyc - t0 >= 49) && (cyc - t0 <= 56), 1'b1);
        waitc(3);
        chk_word({26'h0, fault_flags}, 32'h02);
        chk_bit(drive_ready, 1'b0);
        seek_done <= 1'b1;
        waitc(2);
        seek_done <= 1'b0;
        waitc(5);
        chk_bit(drive_ready, 1'b1);
        at_speed <= 1'b0;
        waitc(5);
        chk_bit(retract_req, 1'b1);
        chk_bit(drive_ready, 1'b0);
        at_speed <= 1'b1;
        $display("test power_up done");
    endtask
    task automatic t_faults();
        write_gate <= 1'b1;
        read_gate <= 1'b1;
        waitc(3);
        read_gate <= 1'b0;
        waitc(70);
        chk_bit(fault_flags[F_WR], 1'b0);
        waitc(15);
        chk_word({26'h0, fault_flags}, 32'h0b);
        write_gate <= 1'b0;
        read_gate <= 1'b1;
        on_cyl <= 1'b0;
        waitc(3);
        read_gate <= 1'b0;
        on_cyl <= 1'b1;
        waitc(6);
        chk_bit(fault_flags[F_OC], 1'b1);
        ctl.fault_clear();
        waitc(4);
        chk_word({26'h0, fault_flags}, 32'h0);
        chk_bit(clear_fault_lamp, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h4);
        waitc(4);
        chk_bit(clear_fault_lamp, 1'b0);
        $display("test faults done");
    endtask
    task automatic t_power_off();
        apb(1'b1, OFS_CTRL, 32'h1);
        waitc(4);
        chk_bit(motor_enable, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h1);
        waitc(3);
        chk_bit(retract_req, 1'b1);
        chk_bit(brake_energize, 1'b1);
        heads_home <= 1'b1;
        while (motor_enable !== 1'b0) @(posedge core_clk);
        chk_bit(brake_energize, 1'b0);
        heads_home <= 1'b0;
        waitc(55);
        apb(1'b0, OFS_STAT, 32'h0);
        chk_word(rd & 32'h3f00, 32'h0100);
        $display("test power_off done");
    endtask
    task automatic t_remote();
        apb(1'b1, OFS_CTRL, 32'h2);
        apb(1'b1, OFS_CTRL, 32'h3);
        waitc(8);
        chk_bit(brake_energize, 1'b0);
        ctl.lines(1'b1);
        waitc(5);
        chk_bit(brake_energize, 1'b1);
        retract_cond <= 1'b1;
        waitc(5);
        chk_bit(retract_req, 1'b1);
        retract_cond <= 1'b0;
        waitc(60);
        chk_bit(brake_energize, 1'b1);
        ctl.lines(1'b0);
        waitc(5);
        chk_bit(retract_req, 1'b1);
        dc_ok <= 1'b0;
        waitc(5);
        chk_bit(fault_flags[F_V], 1'b1);
        $display("test remote done");
    endtask
    task automatic t_sector();
        apb(1'b1, OFS_CFG, 32'h0000_0503);
        sec_count = 0;
        index_mark <= 1'b1;
        waitc(2);
        index_mark <= 1'b0;
        repeat (6) begin
            waitc(2);
            slot_tick <= 1'b1;
            waitc(2);
            slot_tick <= 1'b0;
        end
        waitc(5);
        chk_word(sec_count, 32'h3);
        $display("test sector done");
    endtask
    task automatic t_write();
        write_gate <= 1'b1;
        write_active <= 1'b1;
        waitc(90);
        chk_bit(fault_flags[F_WR], 1'b0);
        write_current <= 1'b0;
        waitc(6);
        chk_bit(fault_flags[F_WR], 1'b1);
        write_gate <= 1'b0;
        write_active <= 1'b0;
        write_current <= 1'b1;
        $display("test write_current done");
    endtask

    // ==========
    // Main sequence.
    initial begin
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_sector();
        t_power_up();
        t_faults();
        t_write();
        t_power_off();
        t_remote();
        tally_and_finish();
    end
endmodule
